//--- core/mic_params.svh
// Constants of the maskable interrupt controller.
// Assumes inclusion by bare name from core/.
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH
`define MIC_A_STATUS   8'h00
`define MIC_A_FLOOR    8'h04
`define MIC_A_VBASE    8'h08
`define MIC_A_TSP      8'h0c
`define MIC_A_SEQ      8'h10
`define MIC_F_D        3'd2
`define MIC_F_I        3'd6
`define MIC_F_U        3'd7
`define MIC_PEND_BIT   3
`define MIC_ENTRY_CYC  20
`define MIC_C_PUSH0    5'd3
`define MIC_C_PUSH3    5'd6
`define MIC_C_VRD0     5'd7
`define MIC_C_VRD3     5'd10
`define MIC_C_VCAP0    5'd9
`define MIC_C_VCAP3    5'd12
`define MIC_C_LOAD     5'd18
`define MIC_C_END      5'd19
`define MIC_R_RD3      5'd2
`define MIC_R_CAP0     5'd1
`define MIC_R_LOAD     5'd4
`define MIC_R_END      5'd5
`define MIC_INFO_ADDR  20'h00000
`define MIC_V_SPEC     20'h0fff0
`define MIC_V_ABRK     20'h0fff4
`define MIC_V_AMATCH   20'h0ffe8
`define MIC_V_STEP     20'h0ffec
`define MIC_LVL_MAX    3'h7
`define MIC_SW_USER    6'h20
`endif

//--- core/mic_pkg.sv
// Types of the maskable interrupt controller.
// Assumes nothing of its surroundings.
`default_nettype none
package mic_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_RET} mic_state_t;
    typedef enum logic [1:0] {K_MASK, K_SPEC7, K_KEEP, K_SOFT} mic_kind_t;
endpackage
`default_nettype wire

//--- core/mic_ctrl.sv
// Maskable interrupt acceptance, priority and entry/return sequencer.
// Assumes a classic Wishbone master, one clock, and a byte memory port
// whose read data is valid in the cycle after the read is presented.
//
// Local design decisions: the address map and the Wishbone slave port.
`include "mic_params.svh"
`default_nettype none

// How it works
// - Accept only with enable, pending, level above floor.
// - Level zero disables source; seven is highest.
// - Floor n admits level n+1 up; seven blocks.
// - Request sets pending; acknowledgement clears it.
// - Software clears pending by writing zero only.
// - Enable, pending, level, floor stored independently.
// - Judge after instruction ends; entry starts next.
// - Interruptible string instructions are suspended at once.
// - First step reads address zero, clears pending.
// - Save status, clear I, D, U flags; traps 32 up keep U.
// - Push PC high and floor, status, then PC low; load floor, vector.
// - Entry takes exactly twenty cycles.
// - Floor gets source level, seven, or unchanged.
// - Frame: PC high, floor, status, then PC low.
// - Stacking is four byte writes.
// - Return pops status and PC, resumes.
// - Only highest priority request is acknowledged.
// - Equal levels resolved by fixed hardware order.
// - Special sources fixed priority; reset above all.
// - Software traps bypass arbitration, enter immediately.
// - Vector entries are four bytes.
// - Table of 256 bytes at vector base.
module mic_ctrl #(
    parameter int NSRC = 32
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [NSRC-1:0]   req_i,
    input  wire logic [6:0]        special_req_i,
    input  wire logic              instr_done_i,
    input  wire logic              string_busy_i,
    input  wire logic              swtrap_i,
    input  wire logic [5:0]        swtrap_num_i,
    input  wire logic              ret_i,
    input  wire logic [19:0]       pc_i,
    input  wire logic [7:0]        mem_rdata_i,
    output logic                   mem_req_o,
    output logic                   mem_we_o,
    output logic      [19:0]       mem_addr_o,
    output logic      [7:0]        mem_wdata_o,
    output logic      [19:0]       pc_o,
    output logic                   pc_load_o,
    output logic                   suspend_o,
    output logic                   busy_o,
    output logic      [6:0]        special_ack_o,
    output logic      [7:0]        status_o,
    output logic      [2:0]        floor_o
);
    localparam int SW = (NSRC > 1) ? $clog2(NSRC) : 1;

    ////////////////////////////////////////////////////////////////////////
    mic_pkg::mic_state_t state_reg;
    mic_pkg::mic_kind_t  kind_reg;
    logic [4:0]          cnt_reg;
    logic [NSRC-1:0]     pend_reg;
    logic [2:0]          lvl_reg [NSRC];
    logic [7:0]          status_reg;
    logic [7:0]          temp_reg;
    logic [2:0]          floor_reg;
    logic [2:0]          new_lvl_reg;
    logic [19:0]         vbase_reg;
    logic [19:0]         tsp_reg;
    logic [19:0]         ret_pc_reg;
    logic [19:0]         vaddr_reg;
    logic [31:0]         buf_reg;
    logic [5:0]          num_reg;
    logic                win_ok;
    logic [SW-1:0]       win_idx;
    logic [2:0]          win_lvl;
    logic                spec_any;
    logic [2:0]          spec_idx;
    logic                judge;
    logic                go_sw;
    logic                go_spec;
    logic                go_mask;
    logic                go_entry;
    logic                go_ret;
    logic                wr;
    logic                ctrl_hit;
    logic [4:0]          ctrl_idx;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode of a write; it lands at the edge where the master samples ack.
    assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign ctrl_hit = wb_adr_i[7] && ({27'h0, wb_adr_i[6:2]} < 32'(NSRC));
    assign ctrl_idx = wb_adr_i[6:2];

    // Returns true when a write with lane zero hits the given address.
    function automatic logic wr_at(input logic [7:0] a);
        return wr && wb_sel_i[0] && (wb_adr_i == a);
    endfunction

    // Per-source pending flag and level; a new request beats any clear.
    for (genvar i = 0; i < NSRC; i++) begin : g_src
        logic hit;
        logic clr;
        assign hit = wr && wb_sel_i[0] && ctrl_hit && (ctrl_idx == 5'(i));
        assign clr = (hit && !wb_dat_i[`MIC_PEND_BIT])
                   || (go_mask && (win_idx == SW'(i)));
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pend_reg[i] <= 1'b0;
            end else begin
                pend_reg[i] <= req_i[i] || (pend_reg[i] && !clr);
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                lvl_reg[i] <= 3'h0;
            end else if (hit) begin
                lvl_reg[i] <= wb_dat_i[2:0];
            end
        end
    end

    // Highest level above the floor wins; ascending scan keeps lower numbers on ties.
    always_comb begin
        win_ok  = 1'b0;
        win_idx = '0;
        win_lvl = 3'h0;
        for (int i = 0; i < NSRC; i++) begin
            if (pend_reg[i] && lvl_reg[i] > win_lvl && lvl_reg[i] > floor_reg) begin
                win_ok  = 1'b1;
                win_idx = SW'(i);
                win_lvl = lvl_reg[i];
            end
        end
    end

    // Special sources in fixed order, bit zero first.
    always_comb begin
        spec_any = |special_req_i;
        spec_idx = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (special_req_i[i]) begin
                spec_idx = 3'(i);
            end
        end
    end

    // Start decisions of the idle sequencer; special and maskable entries wait for the judging point.
    assign judge    = (state_reg == mic_pkg::ST_IDLE) && (instr_done_i || string_busy_i);
    assign go_sw    = (state_reg == mic_pkg::ST_IDLE) && swtrap_i;
    assign go_spec  = judge && !go_sw && spec_any;
    assign go_mask  = judge && !go_sw && !spec_any && win_ok && status_reg[`MIC_F_I];
    assign go_entry = go_sw || go_spec || go_mask;
    assign go_ret   = (state_reg == mic_pkg::ST_IDLE) && ret_i && !go_entry;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state and step counter.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= mic_pkg::ST_IDLE;
            cnt_reg   <= 5'h0;
        end else begin
            unique case (state_reg)
                mic_pkg::ST_IDLE: begin
                    cnt_reg <= 5'h0;
                    if (go_entry) begin
                        state_reg <= mic_pkg::ST_ENTRY;
                    end else if (go_ret) begin
                        state_reg <= mic_pkg::ST_RET;
                    end
                end
                mic_pkg::ST_ENTRY: begin
                    cnt_reg <= cnt_reg + 5'h1;
                    if (cnt_reg == `MIC_C_END) begin
                        state_reg <= mic_pkg::ST_IDLE;
                    end
                end
                mic_pkg::ST_RET: begin
                    cnt_reg <= cnt_reg + 5'h1;
                    if (cnt_reg == `MIC_R_END) begin
                        state_reg <= mic_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Captures what the accepted event needs: kind, level, vector, return PC.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kind_reg    <= mic_pkg::K_MASK;
            new_lvl_reg <= 3'h0;
            vaddr_reg   <= 20'h0;
            ret_pc_reg  <= 20'h0;
            num_reg     <= 6'h0;
        end else if (go_entry) begin
            ret_pc_reg <= pc_i;
            if (go_sw) begin
                kind_reg  <= mic_pkg::K_SOFT;
                num_reg   <= swtrap_num_i;
                vaddr_reg <= vbase_reg + {12'h0, swtrap_num_i, 2'b00};
            end else if (go_spec) begin
                kind_reg    <= (spec_idx <= 3'd4) ? mic_pkg::K_SPEC7 : mic_pkg::K_KEEP;
                new_lvl_reg <= `MIC_LVL_MAX;
                num_reg     <= 6'h0;
                unique case (spec_idx)
                    3'd4:    vaddr_reg <= `MIC_V_ABRK;
                    3'd5:    vaddr_reg <= `MIC_V_AMATCH;
                    3'd6:    vaddr_reg <= `MIC_V_STEP;
                    default: vaddr_reg <= `MIC_V_SPEC;
                endcase
            end else begin
                kind_reg    <= mic_pkg::K_MASK;
                new_lvl_reg <= win_lvl;
                num_reg     <= 6'(win_idx);
                vaddr_reg   <= vbase_reg + {12'h0, 6'(win_idx), 2'b00};
            end
        end
    end

    // Status word: saved, flags cleared on entry, restored on return.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 8'h0;
            temp_reg   <= 8'h0;
        end else if (go_entry) begin
            temp_reg                <= status_reg;
            status_reg[`MIC_F_I]    <= 1'b0;
            status_reg[`MIC_F_D]    <= 1'b0;
            if (!(go_sw && swtrap_num_i >= `MIC_SW_USER)) begin
                status_reg[`MIC_F_U] <= 1'b0;
            end
        end else if (state_reg == mic_pkg::ST_RET && cnt_reg == `MIC_R_LOAD) begin
            status_reg <= buf_reg[23:16];
        end else if (wr_at(`MIC_A_STATUS)) begin
            status_reg <= wb_dat_i[7:0];
        end
    end

    // Level floor, vector base and trap stack pointer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            floor_reg <= 3'h0;
            vbase_reg <= 20'h0;
            tsp_reg   <= 20'h0;
        end else begin
            if (state_reg == mic_pkg::ST_ENTRY && cnt_reg == `MIC_C_LOAD) begin
                if (kind_reg == mic_pkg::K_MASK || kind_reg == mic_pkg::K_SPEC7) begin
                    floor_reg <= new_lvl_reg;
                end
                tsp_reg <= tsp_reg - 20'h4;
            end else if (state_reg == mic_pkg::ST_RET && cnt_reg == `MIC_R_LOAD) begin
                // The top frame byte is still on the memory port in this cycle.
                floor_reg <= mem_rdata_i[2:0];
                tsp_reg   <= tsp_reg + 20'h4;
            end else begin
                if (wr_at(`MIC_A_FLOOR)) begin
                    floor_reg <= wb_dat_i[2:0];
                end
                if (wr_at(`MIC_A_TSP)) begin
                    tsp_reg <= wb_dat_i[19:0];
                end
            end
            if (wr_at(`MIC_A_VBASE)) begin
                vbase_reg <= {wb_dat_i[19:8], 8'h0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory port: info read, four byte pushes, vector or frame reads.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= 20'h0;
            mem_wdata_o <= 8'h0;
        end else begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_wdata_o <= 8'h0;
            if (go_entry) begin
                mem_req_o  <= 1'b1;
                mem_addr_o <= `MIC_INFO_ADDR;
            end else if (go_ret) begin
                mem_req_o  <= 1'b1;
                mem_addr_o <= tsp_reg;
            end else if (state_reg == mic_pkg::ST_ENTRY) begin
                if (cnt_reg >= `MIC_C_PUSH0 && cnt_reg <= `MIC_C_PUSH3) begin
                    mem_req_o  <= 1'b1;
                    mem_we_o   <= 1'b1;
                    mem_addr_o <= tsp_reg - 20'(cnt_reg - `MIC_C_PUSH0) - 20'h1;
                    unique case (cnt_reg - `MIC_C_PUSH0)
                        5'd0:    mem_wdata_o <= {ret_pc_reg[19:16], 1'b0, floor_reg};
                        5'd1:    mem_wdata_o <= temp_reg;
                        5'd2:    mem_wdata_o <= ret_pc_reg[15:8];
                        default: mem_wdata_o <= ret_pc_reg[7:0];
                    endcase
                end else if (cnt_reg >= `MIC_C_VRD0 && cnt_reg <= `MIC_C_VRD3) begin
                    mem_req_o  <= 1'b1;
                    mem_addr_o <= vaddr_reg + 20'(cnt_reg - `MIC_C_VRD0);
                end
            end else if (state_reg == mic_pkg::ST_RET && cnt_reg <= `MIC_R_RD3) begin
                mem_req_o  <= 1'b1;
                mem_addr_o <= tsp_reg + 20'(cnt_reg) + 20'h1;
            end
        end
    end

    // Collects returning bytes, low address first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_reg <= 32'h0;
        end else if (state_reg == mic_pkg::ST_ENTRY && cnt_reg >= `MIC_C_VCAP0
                     && cnt_reg <= `MIC_C_VCAP3) begin
            buf_reg[8*(cnt_reg-`MIC_C_VCAP0) +: 8] <= mem_rdata_i;
        end else if (state_reg == mic_pkg::ST_RET && cnt_reg >= `MIC_R_CAP0
                     && cnt_reg <= `MIC_R_LOAD) begin
            buf_reg[8*(cnt_reg-`MIC_R_CAP0) +: 8] <= mem_rdata_i;
        end
    end

    // CPU-facing pulses and levels.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o          <= 20'h0;
            pc_load_o     <= 1'b0;
            suspend_o     <= 1'b0;
            busy_o        <= 1'b0;
            special_ack_o <= 7'h0;
        end else begin
            pc_load_o     <= 1'b0;
            special_ack_o <= 7'h0;
            suspend_o     <= go_entry && !go_sw && string_busy_i && !instr_done_i;
            busy_o        <= go_entry || go_ret || (state_reg != mic_pkg::ST_IDLE
                             && !(cnt_reg == `MIC_C_END || (state_reg == mic_pkg::ST_RET
                             && cnt_reg == `MIC_R_END)));
            if (go_spec) begin
                special_ack_o[spec_idx] <= 1'b1;
            end
            if (state_reg == mic_pkg::ST_ENTRY && cnt_reg == `MIC_C_LOAD) begin
                pc_load_o <= 1'b1;
                pc_o      <= buf_reg[19:0];
            end else if (state_reg == mic_pkg::ST_RET && cnt_reg == `MIC_R_LOAD) begin
                pc_load_o <= 1'b1;
                pc_o      <= {mem_rdata_i[7:4], buf_reg[15:0]};
            end
        end
    end

    // Visible state copies.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_o <= 8'h0;
            floor_o  <= 3'h0;
        end else begin
            status_o <= status_reg;
            floor_o  <= floor_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, unmapped reads give zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h0;
            if (wb_adr_i[7]) begin
                if (ctrl_hit) begin
                    wb_dat_o <= {28'h0, pend_reg[SW'(ctrl_idx)], lvl_reg[SW'(ctrl_idx)]};
                end
            end else begin
                unique case (wb_adr_i)
                    `MIC_A_STATUS: wb_dat_o <= {24'h0, status_reg};
                    `MIC_A_FLOOR:  wb_dat_o <= {29'h0, floor_reg};
                    `MIC_A_VBASE:  wb_dat_o <= {12'h0, vbase_reg};
                    `MIC_A_TSP:    wb_dat_o <= {12'h0, tsp_reg};
                    `MIC_A_SEQ:    wb_dat_o <= {16'h0, 2'(kind_reg), num_reg, 6'(state_reg), 2'h0};
                    default:       wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_entry_start;
        state_reg == mic_pkg::ST_IDLE ##1 state_reg == mic_pkg::ST_ENTRY;
    endsequence
    sequence s_pushes;
        (mem_we_o && mem_req_o) [*4];
    endsequence

    a_accept_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        go_mask |-> status_reg[`MIC_F_I] && pend_reg[win_idx] && win_lvl > floor_reg)
        else $error("maskable accepted without its conditions");
    a_floor_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        floor_reg == `MIC_LVL_MAX |-> !go_mask)
        else $error("floor seven let a maskable source in");
    a_level_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        go_mask |-> lvl_reg[win_idx] != 3'h0)
        else $error("level zero source accepted");
    a_pend_set: assert property (@(posedge clk_i) disable iff (rst_i)
        |req_i |=> (pend_reg & $past(req_i)) == $past(req_i))
        else $error("request did not set pending");
    a_entry_len: assert property (@(posedge clk_i) disable iff (rst_i)
        s_entry_start |-> ##19 pc_load_o ##1 state_reg == mic_pkg::ST_IDLE)
        else $error("entry did not take twenty cycles");
    a_four_writes: assert property (@(posedge clk_i) disable iff (rst_i)
        s_entry_start |-> ##4 s_pushes ##1 !mem_we_o)
        else $error("stacking was not four byte writes");
    a_flags_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        go_entry |=> !status_reg[`MIC_F_I] && !status_reg[`MIC_F_D] && temp_reg == $past(status_reg))
        else $error("flags not saved and cleared on entry");
    a_floor_load: assert property (@(posedge clk_i) disable iff (rst_i)
        go_mask |-> ##20 floor_reg == $past(win_lvl, 20))
        else $error("floor not loaded with accepted level");
    a_special_first: assert property (@(posedge clk_i) disable iff (rst_i)
        judge && spec_any && !swtrap_i |-> !go_mask)
        else $error("maskable taken over a special source");
endmodule
`default_nettype wire

//--- verification/mic_mem_model.sv
// Byte memory that stands on the far side of the sequencer's memory port.
// Assumes one byte access per strobe and read data taken one cycle later.
`default_nettype none
module mic_mem_model (
    input  wire logic        clk_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [19:0] mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    output logic      [7:0]  mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:511];
    // Unwritten bytes hold a pattern derived from their address.
    initial begin
        for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'ha5;
    end
    // Writes land at once; cycles without a read show the inverse of the previous output byte.
    always_ff @(posedge clk_i) begin
        if (mem_req_i && mem_we_i) mem[mem_addr_i[8:0]] <= mem_wdata_i;
        mem_rdata_o <= (mem_req_i && !mem_we_i) ? mem[mem_addr_i[8:0]] : ~mem_rdata_o;
    end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the interrupt controller: bus, entry and return.
// Assumes the byte memory model above on the memory port.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, cyc, stb, we, done, ret, busy;
    logic [7:0] adr, rd;
    logic [31:0] dat, q, seed, dato, bad_count, comparisons;
    logic [31:0] req;
    logic [19:0] pc, pco, maddr, epc;
    logic [7:0] wd, st;
    logic [2:0] fl;
    logic ack, mreq, mwe, pld;
    logic sbusy, swt, susp;
    logic [5:0] swn;
    logic [6:0] sreq, sack;
    int n;
    mic_ctrl mic_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .req_i(req),
        .special_req_i(sreq), .instr_done_i(done), .string_busy_i(sbusy), .swtrap_i(swt),
        .swtrap_num_i(swn), .ret_i(ret), .pc_i(pc), .mem_rdata_i(rd), .mem_req_o(mreq),
        .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(wd), .pc_o(pco), .pc_load_o(pld),
        .suspend_o(susp), .busy_o(busy), .special_ack_o(sack), .status_o(st), .floor_o(fl));
    mic_mem_model mic_mem_model_i (.clk_i(clk_i), .mem_req_i(mreq), .mem_we_i(mwe),
        .mem_addr_i(maddr), .mem_wdata_i(wd), .mem_rdata_o(rd));
    ////////////////////////////////////////////////////////////////////////
    // Random source and expectation helpers.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] pat(input logic [8:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction
    // Handler address as stored little-endian at a vector entry of the model.
    function automatic logic [31:0] vec(input logic [8:0] a);
        logic [7:0] hi;
        hi = pat(a + 9'h2);
        return {12'h0, hi[3:0], pat(a + 9'h1), pat(a)};
    endfunction
    // Compare a value with its expectation and count the result.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    // Count edges until the design asks the CPU to load its program counter.
    task automatic wait_load();
        n = 0;
        do begin @(posedge clk_i); n++; end while (pld !== 1'b1 && n < 60);
    endtask
    task automatic results();
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        bad_count = bad_count + 1;
        results();
    end
    // Main sequence: setup, arbitrated entry, pending handling, return.
    initial begin
        rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; done = 0; ret = 0; req = 0;
        bad_count = 0; comparisons = 0; seed = 32'd74157; pc = 0;
        sreq = 0; sbusy = 0; swt = 0; swn = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({busy, st, 1'b0, fl}, 32'h0);
        wb(0, 8'h14, 0); chk(q, 32'h0);
        seed = lfsr(lfsr(seed));
        pc <= seed[19:0];
        epc = seed[19:0];
        // Sources are configured while quiet; no request is raised yet.
        wb(1, 8'h08, 32'h100); wb(1, 8'h0c, 32'h40); wb(1, 8'h04, 32'h2);
        wb(1, 8'h94, 32'h3); wb(1, 8'h88, 32'h3); wb(1, 8'ha4, 32'h2);
        wb(1, 8'h00, 32'h40); wb(0, 8'h00, 0); chk(q, 32'h40);
        wb(0, 8'h04, 0); chk(q, 32'h2);
        @(posedge clk_i); req <= 32'h224;
        @(posedge clk_i); req <= 32'h0;
        @(posedge clk_i); wb(0, 8'ha4, 0); chk(q, 32'ha);
        @(posedge clk_i); done <= 1'b1;
        @(posedge clk_i); done <= 1'b0;
        wait_load();
        chk(n, 20);
        chk(pco, vec(9'h108));
        @(posedge clk_i);
        chk(fl, 3);
        chk(st, 8'h00);
        chk(mic_mem_model_i.mem[9'h3f], {epc[19:16], 4'h2});
        chk(mic_mem_model_i.mem[9'h3e], 8'h40);
        chk(mic_mem_model_i.mem[9'h3d], epc[15:8]);
        chk(mic_mem_model_i.mem[9'h3c], epc[7:0]);
        repeat (2) @(posedge clk_i);
        chk(busy, 0);
        wb(0, 8'h88, 0); chk(q, 32'h3);
        wb(0, 8'h94, 0); chk(q, 32'hb);
        wb(1, 8'h94, 32'h3); wb(0, 8'h94, 0); chk(q, 32'h3);
        wb(1, 8'hb0, 32'h4); wb(0, 8'hb0, 0); chk(q, 32'h4);
        @(posedge clk_i); ret <= 1'b1;
        @(posedge clk_i); ret <= 1'b0;
        wait_load();
        chk(n, 6);
        chk(pco, epc);
        @(posedge clk_i);
        chk({st, 1'b0, fl}, {8'h40, 4'h2});
        wb(0, 8'h0c, 0); chk(q, 32'h40);
        // Software trap 33 keeps the stack select flag and the floor.
        wb(1, 8'h00, 32'hc0);
        @(posedge clk_i);
        swt <= 1'b1;
        swn <= 6'h21;
        @(posedge clk_i);
        swt <= 1'b0;
        wait_load();
        chk(n, 20);
        chk(pco, vec(9'h184));
        @(posedge clk_i);
        chk({st, 1'b0, fl}, {8'h80, 4'h2});
        chk(mic_mem_model_i.mem[9'h3e], 8'hc0);
        // A watchdog request during a string instruction suspends it.
        @(posedge clk_i);
        sreq <= 7'h01;
        sbusy <= 1'b1;
        @(posedge clk_i);
        sreq <= 7'h00;
        sbusy <= 1'b0;
        @(posedge clk_i);
        chk({susp, sack}, {1'b1, 7'h01});
        wait_load();
        chk(n, 19);
        chk(pco, vec(9'h1f0));
        @(posedge clk_i);
        chk({st, 1'b0, fl}, {8'h00, 4'h7});
        results();
    end
endmodule
`default_nettype wire
